// *** rtl/spwc_regs.vh ***
`ifndef SPWC_REGS_VH
`define SPWC_REGS_VH

// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
`define SPWC_ADDR_CTRL      4'h0
`define SPWC_ADDR_OPA       4'h4
`define SPWC_ADDR_OPB       4'h8
`define SPWC_ADDR_STATUS    4'hC

// ---------------------------------------------
// register reset values
// ---------------------------------------------
`define SPWC_OPA_RESET      32'h00000000
`define SPWC_OPB_RESET      32'h00000000
`define SPWC_RDAT_RESET     32'h00000000
`define SPWC_STAT_RESET     32'h00000000

// ---------------------------------------------
// control fields
// ---------------------------------------------
`define SPWC_CTRL_EN_N      0
`define SPWC_CTRL_USE_SUB   1
`define SPWC_CTRL_MODE_LO   2
`define SPWC_CTRL_MODE_HI   3
`define SPWC_CTRL_START     4
`define SPWC_CTRL_RESET     5'h00

// ---------------------------------------------
// status fields
// ---------------------------------------------
`define SPWC_STAT_MAG       0
`define SPWC_STAT_DIFF      1
`define SPWC_STAT_GT        2
`define SPWC_STAT_LT        3
`define SPWC_STAT_EQ        4
`define SPWC_STAT_IDENT     5

// ---------------------------------------------
// serial modes
// ---------------------------------------------
`define SPWC_MODE_IDENT     2'h0
`define SPWC_MODE_LSB_MAG   2'h1
`define SPWC_MODE_MSB_MAG   2'h2
`define SPWC_MODE_MSB_GTLT  2'h3

// ---------------------------------------------
// comparator slice geometry
// ---------------------------------------------
`define SPWC_SLICE_W        5

`endif

// *** rtl/spwc_top.v ***
// Overview of operation
// - identity mode sets difference flag on any mismatching bit; held until clear.
// - after last bit, difference set means unequal, cleared means equal.
// - identity verdict does not depend on bit order.
// - parallel identity XORs each bit pair; any mismatch drops equality.
// - serial magnitude reports greater, less, equal on two flags.
// - LSB-first: A1B0 sets magnitude, A0B1 clears it, mismatch sets difference.
// - MSB-first: first differing position alone decides; later bits change nothing.
// - MSB-first: greater flag set only on A1B0 with no earlier difference.
// - MSB-first: difference flag set on first mismatch, held until new clear.
// - alternative MSB-first: one flag greater, other flag less, both clear equal.
// - parallel comparator gives three exclusive active-high greater, less, equal outputs.
// - active-low enable high forces all three parallel outputs low.
// - equal output derived from greater and less, asserting when neither active.
// - wide comparison built from 5-bit slices combined in parallel, not rippled.
// - optional magnitude by subtracting B from A: sign and zero give result.
//
// Chosen here: the address map and the Wishbone register port.

`timescale 1ns/1ps
`default_nettype none

`include "spwc_regs.vh"

module spwc_top #(
	parameter PW = 30
) (
	input  wire        I_CLOCK,
	input  wire        I_NRST,
	// wishbone classic slave
	input  wire        I_WB_CYC,
	input  wire        I_WB_STB,
	input  wire        I_WB_WE,
	input  wire [3:0]  I_WB_ADR,
	input  wire [3:0]  I_WB_SEL,
	input  wire [31:0] I_WB_DAT,
	output wire [31:0] O_WB_DAT,
	output wire        O_WB_ACK,
	// serial bit stream from surrounding logic
	input  wire        I_SER_START,
	input  wire        I_SER_VALID,
	input  wire        I_SER_A,
	input  wire        I_SER_B,
	output wire        O_MAG_FLAG,
	output wire        O_DIFF_FLAG,
	// parallel results
	output wire        O_PAR_GT,
	output wire        O_PAR_LT,
	output wire        O_PAR_EQ
);

	localparam NS = (PW + `SPWC_SLICE_W - 1) / `SPWC_SLICE_W;
	localparam XW = NS * `SPWC_SLICE_W;

	// ---------------------------------------------
	// register file
	// ---------------------------------------------
	reg  [4:0]    ctrl_reg;
	reg  [31:0]   opa_reg;
	reg  [31:0]   opb_reg;
	reg           ack_reg;
	reg  [31:0]   rdat_reg;
	reg           sw_start_reg;

	reg           mag_reg;
	reg           diff_reg;
	reg           gt_reg;
	reg           lt_reg;
	reg           eq_reg;
	reg           ident_reg;

	wire          wb_req;
	wire          wb_wr;
	wire [1:0]    mode;
	wire          en_n;
	wire          use_sub;
	reg  [31:0]   status_word;
	reg  [31:0]   rdat_next;

	assign wb_req  = I_WB_CYC & I_WB_STB;
	// write lands on the edge that samples ack
	assign wb_wr   = wb_req & ack_reg & I_WB_WE;
	assign mode    = ctrl_reg[`SPWC_CTRL_MODE_HI:`SPWC_CTRL_MODE_LO];
	assign en_n    = ctrl_reg[`SPWC_CTRL_EN_N];
	assign use_sub = ctrl_reg[`SPWC_CTRL_USE_SUB];

	// ---------------------------------------------
	// status word
	// ---------------------------------------------
	// spare bits read zero so software can mask freely
	always @* begin
		status_word                    = `SPWC_STAT_RESET;
		status_word[`SPWC_STAT_MAG]    = mag_reg;
		status_word[`SPWC_STAT_DIFF]   = diff_reg;
		status_word[`SPWC_STAT_GT]     = gt_reg;
		status_word[`SPWC_STAT_LT]     = lt_reg;
		status_word[`SPWC_STAT_EQ]     = eq_reg;
		status_word[`SPWC_STAT_IDENT]  = ident_reg;
	end

	always @* begin
		case (I_WB_ADR)
			`SPWC_ADDR_CTRL:   rdat_next = {27'h0000000, ctrl_reg};
			`SPWC_ADDR_OPA:    rdat_next = opa_reg;
			`SPWC_ADDR_OPB:    rdat_next = opb_reg;
			`SPWC_ADDR_STATUS: rdat_next = status_word;
			// unmapped reads as zero, still acknowledged
			default:           rdat_next = 32'h00000000;
		endcase
	end

	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  sel;
		integer k;
		begin
			merge_bytes = old_val;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
				end
			end
		end
	endfunction

	always @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			ack_reg  <= 1'b0;
			rdat_reg <= `SPWC_RDAT_RESET;
		end else begin
			// one wait state, ack drops the cycle after
			ack_reg  <= wb_req & ~ack_reg;
			rdat_reg <= rdat_next;
		end
	end

	always @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			ctrl_reg     <= `SPWC_CTRL_RESET;
			opa_reg      <= `SPWC_OPA_RESET;
			opb_reg      <= `SPWC_OPB_RESET;
			sw_start_reg <= 1'b0;
		end else begin
			sw_start_reg <= 1'b0;
			if (wb_wr) begin
				case (I_WB_ADR)
					`SPWC_ADDR_CTRL: begin
						if (I_WB_SEL[0]) begin
							ctrl_reg[`SPWC_CTRL_EN_N]    <= I_WB_DAT[`SPWC_CTRL_EN_N];
							ctrl_reg[`SPWC_CTRL_USE_SUB] <= I_WB_DAT[`SPWC_CTRL_USE_SUB];
							ctrl_reg[`SPWC_CTRL_MODE_HI:`SPWC_CTRL_MODE_LO]
								<= I_WB_DAT[`SPWC_CTRL_MODE_HI:`SPWC_CTRL_MODE_LO];
							// start is a pulse, never stored, so it reads 0
							ctrl_reg[`SPWC_CTRL_START]   <= 1'b0;
							sw_start_reg                 <= I_WB_DAT[`SPWC_CTRL_START];
						end
					end
					`SPWC_ADDR_OPA: opa_reg <= merge_bytes(opa_reg, I_WB_DAT, I_WB_SEL);
					`SPWC_ADDR_OPB: opb_reg <= merge_bytes(opb_reg, I_WB_DAT, I_WB_SEL);
					default: begin
					end
				endcase
			end
		end
	end

	// ---------------------------------------------
	// serial comparator
	// ---------------------------------------------
	wire   ser_clear;
	wire   bit_gt;
	wire   bit_lt;
	wire   bit_ne;
	reg    mag_next;
	reg    diff_next;

	assign ser_clear = I_SER_START | sw_start_reg;
	assign bit_gt    = I_SER_A & ~I_SER_B;
	assign bit_lt    = ~I_SER_A & I_SER_B;
	assign bit_ne    = I_SER_A ^ I_SER_B;

	// clear wins over a bit in the same cycle
	always @* begin
		mag_next  = mag_reg;
		diff_next = diff_reg;
		if (ser_clear) begin
			mag_next  = 1'b0;
			diff_next = 1'b0;
		end else if (I_SER_VALID) begin
			case (mode)
				`SPWC_MODE_IDENT: begin
					diff_next = diff_reg | bit_ne;
				end
				`SPWC_MODE_LSB_MAG: begin
					if (bit_gt) begin
						mag_next = 1'b1;
					end else if (bit_lt) begin
						mag_next = 1'b0;
					end
					diff_next = diff_reg | bit_ne;
				end
				`SPWC_MODE_MSB_MAG: begin
					if (bit_gt && !diff_reg) begin
						mag_next = 1'b1;
					end
					diff_next = diff_reg | bit_ne;
				end
				default: begin
					if (!mag_reg && !diff_reg) begin
						mag_next  = bit_gt;
						diff_next = bit_lt;
					end
				end
			endcase
		end
	end

	always @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			mag_reg  <= 1'b0;
			diff_reg <= 1'b0;
		end else begin
			mag_reg  <= mag_next;
			diff_reg <= diff_next;
		end
	end

	// ---------------------------------------------
	// parallel comparator slices
	// ---------------------------------------------
	wire [XW-1:0] pa;
	wire [XW-1:0] pb;
	wire [NS-1:0] s_gt;
	wire [NS-1:0] s_lt;
	wire [NS-1:0] s_ne;
	wire [NS-1:0] win_gt;
	wire [NS-1:0] win_lt;
	wire          tree_gt;
	wire          tree_lt;
	wire          sub_gt;
	wire          sub_lt;
	wire          any_gt;
	wire          any_lt;
	wire [PW:0]   sub_diff;
	reg           gt_next;
	reg           lt_next;
	reg           eq_next;
	reg           ident_next;

	// ---------------------------------------------
	// operand padding
	// ---------------------------------------------
	// a zero-width pad is illegal, so only pad when slices overhang
	generate
		if (XW > PW) begin : g_pad
			assign pa = {{(XW-PW){1'b0}}, opa_reg[PW-1:0]};
			assign pb = {{(XW-PW){1'b0}}, opb_reg[PW-1:0]};
		end else begin : g_nopad
			assign pa = opa_reg[PW-1:0];
			assign pb = opb_reg[PW-1:0];
		end
	endgenerate

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi = gi + 1) begin : g_slice
			wire [`SPWC_SLICE_W-1:0] sa;
			wire [`SPWC_SLICE_W-1:0] sb;
			wire [NS-1:0]            higher;
			assign sa = pa[gi*`SPWC_SLICE_W +: `SPWC_SLICE_W];
			assign sb = pb[gi*`SPWC_SLICE_W +: `SPWC_SLICE_W];
			assign s_gt[gi] = (sa > sb);
			assign s_lt[gi] = (sa < sb);
			assign s_ne[gi] = |(sa ^ sb);
			// no ripple: each slice sees all higher slices at once
			assign higher = s_ne & ~({NS{1'b1}} >> (NS - 1 - gi));
			assign win_gt[gi] = s_gt[gi] & ~(|higher);
			assign win_lt[gi] = s_lt[gi] & ~(|higher);
		end
	endgenerate

	assign tree_gt = |win_gt;
	assign tree_lt = |win_lt;

	// borrow means less, nonzero means greater
	assign sub_diff = {1'b0, opa_reg[PW-1:0]} - {1'b0, opb_reg[PW-1:0]};
	assign sub_lt   = sub_diff[PW];
	assign sub_gt   = ~sub_diff[PW] & (|sub_diff[PW-1:0]);

	assign any_gt = use_sub ? sub_gt : tree_gt;
	assign any_lt = use_sub ? sub_lt : tree_lt;

	// ---------------------------------------------
	// parallel result registers
	// ---------------------------------------------
	always @* begin
		gt_next    = ~en_n & any_gt;
		lt_next    = ~en_n & any_lt;
		eq_next    = ~en_n & ~any_gt & ~any_lt;
		ident_next = ~(|s_ne);
	end

	always @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			gt_reg    <= 1'b0;
			lt_reg    <= 1'b0;
			eq_reg    <= 1'b0;
			ident_reg <= 1'b0;
		end else begin
			gt_reg    <= gt_next;
			lt_reg    <= lt_next;
			eq_reg    <= eq_next;
			ident_reg <= ident_next;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign O_WB_DAT    = rdat_reg;
	assign O_WB_ACK    = ack_reg;
	assign O_MAG_FLAG  = mag_reg;
	assign O_DIFF_FLAG = diff_reg;
	assign O_PAR_GT    = gt_reg;
	assign O_PAR_LT    = lt_reg;
	assign O_PAR_EQ    = eq_reg;

endmodule

`default_nettype wire

// *** testbench/spwc_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// port checks
// ----------------------------
module spwc_sva (
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic O_WB_ACK,
	input wire logic I_SER_START,
	input wire logic I_SER_VALID,
	input wire logic I_SER_A,
	input wire logic I_SER_B,
	input wire logic O_MAG_FLAG,
	input wire logic O_DIFF_FLAG,
	input wire logic O_PAR_GT,
	input wire logic O_PAR_LT,
	input wire logic O_PAR_EQ
);
	// a bus write may clear the flags, so hold checks skip bus traffic
	logic bus_reg;
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST)
			bus_reg <= 1'b0;
		else
			bus_reg <= I_WB_CYC;
	end
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_NRST);
	sequence s_req;
		I_WB_CYC && I_WB_STB && !O_WB_ACK;
	endsequence
	sequence s_quiet;
		!I_SER_START && !I_WB_CYC && !bus_reg;
	endsequence
	a_wb_answer: assert property (s_req |=> O_WB_ACK)
		else $error("no ack one cycle after request");
	a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack longer than one cycle");
	a_par_excl: assert property ($onehot0({O_PAR_GT, O_PAR_LT, O_PAR_EQ}))
		else $error("parallel outputs not exclusive");
	a_flag_clear: assert property (I_SER_START |=> !O_MAG_FLAG && !O_DIFF_FLAG)
		else $error("flags not cleared by start");
	a_idle_hold: assert property (s_quiet ##0 !I_SER_VALID |=> $stable({O_MAG_FLAG, O_DIFF_FLAG}))
		else $error("flags moved without a bit");
	a_match_hold: assert property (s_quiet ##0 I_SER_VALID && I_SER_A == I_SER_B
		|=> $stable({O_MAG_FLAG, O_DIFF_FLAG}))
		else $error("matching bits changed flags");
	a_diff_cause: assert property ($rose(O_DIFF_FLAG) |-> $past(I_SER_VALID && I_SER_A != I_SER_B))
		else $error("difference flag set without mismatch");
	a_mag_cause: assert property ($rose(O_MAG_FLAG) |-> $past(I_SER_VALID && I_SER_A && !I_SER_B))
		else $error("magnitude flag set without a greater bit");
	a_diff_sticky: assert property (s_quiet ##0 O_DIFF_FLAG |=> O_DIFF_FLAG)
		else $error("difference flag dropped");
endmodule
bind spwc_top spwc_sva u_sva (.I_CLOCK, .I_NRST, .I_WB_CYC, .I_WB_STB, .O_WB_ACK, .I_SER_START,
	.I_SER_VALID, .I_SER_A, .I_SER_B, .O_MAG_FLAG, .O_DIFF_FLAG, .O_PAR_GT, .O_PAR_LT, .O_PAR_EQ);
`default_nettype wire

// *** testbench/spwc_ser_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------
// upstream bit source
// ----------------------------
module spwc_ser_src (
	input  wire logic i_clk,
	output var logic  o_start,
	output var logic  o_valid,
	output var logic  o_a,
	output var logic  o_b
);
	initial begin
		o_start = 1'b0;
		o_valid = 1'b0;
		o_a = 1'b0;
		o_b = 1'b1;
	end
	// clear, then one pair per clock; gap adds one idle clock before the fourth pair
	task automatic send(input logic [7:0] a, input logic [7:0] b, input logic msb, input logic gap);
		int i;
		@(posedge i_clk);
		o_start <= 1'b1;
		@(posedge i_clk);
		o_start <= 1'b0;
		for (i = 0; i < 8; i++) begin
			// idle lines show junk so ignored bits are really ignored
			if (gap && i == 3) begin
				o_valid <= 1'b0;
				o_a <= ~o_a;
				o_b <= ~o_b;
				@(posedge i_clk);
			end
			o_valid <= 1'b1;
			o_a <= msb ? a[7 - i] : a[i];
			o_b <= msb ? b[7 - i] : b[i];
			@(posedge i_clk);
		end
		o_valid <= 1'b0;
		o_a <= ~o_a;
		o_b <= ~o_b;
	endtask
endmodule
`default_nettype wire

// *** testbench/spwc_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spwc_regs.vh"
// ----------------------------
// bench
// ----------------------------
module spwc_top_tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [3:0]  sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [31:0] odat, rdat;
	logic        ack, st, vl, sa, sb, mag, diff, gt, lt, eq;
	logic [31:0] seed = 32'hD4EAA110;
	int          err_total = 0;
	int          total_checks = 0;
	always #5 clk = ~clk;
	spwc_top #(.PW(30)) u_spwc_top (.I_CLOCK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(odat), .O_WB_ACK(ack),
		.I_SER_START(st), .I_SER_VALID(vl), .I_SER_A(sa), .I_SER_B(sb), .O_MAG_FLAG(mag),
		.O_DIFF_FLAG(diff), .O_PAR_GT(gt), .O_PAR_LT(lt), .O_PAR_EQ(eq));
	spwc_ser_src u_src (.i_clk(clk), .o_start(st), .o_valid(vl), .o_a(sa), .o_b(sb));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [1:0] ser_exp(int m, logic [7:0] x, logic [7:0] y);
		return (m == 3) ? {x > y, x < y} : {m != 0 && x > y, x != y};
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one classic cycle; waits for ack, takes data at that edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = odat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		#100000;
		err_total++;
		test_done();
	end
	initial begin
		logic [31:0] a, b;
		logic [7:0]  x, y;
		logic [2:0]  e;
		int          k, m;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		wb(1'b0, `SPWC_ADDR_CTRL, 32'h0);
		chk("ctrl", rdat, 32'h0);
		for (k = 0; k < 24; k++) begin
			a = rnd() & 32'h3FFFFFFF;
			b = (k % 4 == 0) ? a : (k == 1) ? a ^ 32'h20000000 : rnd() & 32'h3FFFFFFF;
			m = k % 3;
			wb(1'b1, `SPWC_ADDR_CTRL, m);
			wb(1'b1, `SPWC_ADDR_OPA, a);
			wb(1'b1, `SPWC_ADDR_OPB, b);
			@(posedge clk);
			e = (m == 1) ? 3'h0 : {a > b, a < b, a == b};
			chk("par", {gt, lt, eq}, e);
			wb(1'b0, `SPWC_ADDR_STATUS, 32'h0);
			chk("stat", rdat, {a == b, e[0], e[1], e[2], 2'h0});
		end
		for (k = 0; k < 16; k++) begin
			m = k % 4;
			x = rnd();
			y = (k % 5 == 0) ? x : rnd();
			wb(1'b1, `SPWC_ADDR_CTRL, m << 2);
			u_src.send(x, y, m > 1 || (m == 0 && k[2]), k[3]);
			@(posedge clk);
			chk("ser", {mag & (m != 0), diff}, ser_exp(m, x, y));
		end
		@(posedge clk);
		wb(1'b1, `SPWC_ADDR_CTRL, 32'h10);
		@(posedge clk);
		chk("soft", {mag, diff}, 2'h0);
		wb(1'b0, `SPWC_ADDR_CTRL, 32'h0);
		chk("ctrl2", rdat, 32'h0);
		test_done();
	end
endmodule
`default_nettype wire
